// *** core/tss_consts.svh ***
`ifndef TSS_CONSTS_SVH
`define TSS_CONSTS_SVH
// clocking and timing
`define TSS_CLK_HZ        25000000
`define TSS_AUX_HZ        32678
`define TSS_US_PER_S      1000000
`define TSS_WAKE_PER_S    4
`define TSS_PULSE1_US     1003
`define TSS_PULSE2_US     1237
`define TSS_PULSE_MARGIN  1
`define TSS_WAKE_LAT      1
`define TSS_LCD_DIV       64
// tick sequencing
`define TSS_TICK_SENSE_A  4'h4
`define TSS_TICK_LAST     4'h8
// register byte offsets
`define TSS_OFS_CTRL      8'h00
`define TSS_OFS_STATUS    8'h04
`define TSS_OFS_MASK      8'h08
`define TSS_OFS_STATE     8'h0c
`define TSS_OFS_FIRST     8'h10
`define TSS_OFS_RTC       8'h14
// reset values
`define TSS_ARM_SECS_RST  8'h0a
`define TSS_CTRL_RST      9'h000
// field positions
`define TSS_ST_WAKE       0
`define TSS_ST_SAMPLE     1
`define TSS_ST_TAMPER     2
`define TSS_ST_SUPPLY     3
`define TSS_NUM_EV        4
`endif

// *** core/tss_pkg.sv ***
package tss_pkg;
  typedef enum logic [1:0] {
    TSS_IDLE  = 2'b00,
    TSS_PULSE = 2'b01,
    TSS_READ  = 2'b10
  } tss_seq_type;
  typedef struct packed {
    logic       wr;
    logic [7:0] addr;
  } tss_aphase_type;
endpackage : tss_pkg

// *** core/tss_top.sv ***
`timescale 1ns/1ps
`include "tss_consts.svh"
// Overview of operation
// R1 - wake timer counts the 32 kHz auxiliary clock, running during sleep
// R2 - wake timer counts up/down and raises a wake event four times a second
// R3 - every wake tick refreshes the main/backup supply indicator
// R4 - tick counter reaching 8 clears itself and advances the displayed parameter
// R5 - tick count 4 or 8 raises sensor enable and arms the pulse timer
// R6 - pulse timer counts aux clock upward, one expiry per arming
// R7 - minimum enable pulse width selectable for one-coil or two-coil boards
// R8 - terminal count compensates wake latency so total enable equals pulse width
// R9 - sensor read only after arming flag, set after configured seconds since reset
// R10 - display tamper indicators update after each read on either supply
// R11 - tamper LEDs update after a read only while on main supply
// R12 - after update, drop sensor enable and idle pulse timer until next arming
// R13 - display driven four-multiplex, refresh aux clock divided by 64
// R14 - switch to backup when main is gone and backup is above threshold
// R15 - capture first tamper time, held until clear button on main supply releases it; a tamper with clear button recaptures it on backup too
// R16 - pulse minimum 1.003 ms or 1.237 ms, generated slightly longer
// R17 - reset clears tick counter and arming, enable low, pulse timer idle
// R18 - sensor output sampled only in expiry handling while enable is high
module tss_top import tss_pkg::*; #(
  parameter int AUX_PER_SEC = `TSS_AUX_HZ,  // aux ticks per rtc second
  parameter int WAKE_HALF   = `TSS_AUX_HZ / (2 * `TSS_WAKE_PER_S)  // aux ticks per half wake
) (
  input  wire logic        clock,              // 25 MHz system clock
  input  wire logic        resetn,             // async reset, active low
  input  wire logic        hsel,               // ahb slave select
  input  wire logic [31:0] haddr,              // ahb address
  input  wire logic [1:0]  htrans,             // ahb transfer type
  input  wire logic        hwrite,             // ahb write
  input  wire logic [2:0]  hsize,              // ahb size, word only
  input  wire logic [31:0] hwdata,             // ahb write data
  input  wire logic        hready,             // ahb bus ready
  output logic      [31:0] hrdata_reg,         // ahb read data
  output logic             hreadyout_reg,      // ahb slave ready
  output logic             hresp_reg,          // ahb response, always okay
  input  wire logic        sensor_out,         // switch output, high = tamper
  input  wire logic        main_ok,            // main supply above threshold
  input  wire logic        backup_ok,          // backup supply above threshold
  input  wire logic        clear_button,       // releases first tamper capture, only on main supply
  output logic             sensor_en_reg,      // switch enable
  output logic             supply_backup_reg,  // 1 = running from backup
  output logic             lcd_supply_sym_reg, // supply symbol on display
  output logic             lcd_tamper_sym_reg, // tamper symbol on display
  output logic             led_tamper_reg,     // tamper led
  output logic      [1:0]  lcd_com_reg,        // display common phase
  output logic      [1:0]  disp_param_reg,     // displayed parameter index
  output logic             irq_reg             // level interrupt
);
  localparam int AUX_DIV   = `TSS_CLK_HZ / `TSS_AUX_HZ;
  localparam int P1_TICKS  = (`TSS_PULSE1_US * `TSS_AUX_HZ + `TSS_US_PER_S - 1) / `TSS_US_PER_S;
  localparam int P2_TICKS  = (`TSS_PULSE2_US * `TSS_AUX_HZ + `TSS_US_PER_S - 1) / `TSS_US_PER_S;
  localparam int TERM1     = P1_TICKS + `TSS_PULSE_MARGIN - `TSS_WAKE_LAT;
  localparam int TERM2     = P2_TICKS + `TSS_PULSE_MARGIN - `TSS_WAKE_LAT;

  //////////////////////////////////////////////////////////////////////////////
  // auxiliary tick, wake timer, display refresh
  logic [9:0]  aux_div_reg;
  logic        aux_tick;
  logic [12:0] wake_cnt_reg;
  logic        wake_down_reg;
  logic        wake_tick;
  logic [5:0]  lcd_div_reg;

  assign aux_tick  = (aux_div_reg == 10'(AUX_DIV - 1));
  assign wake_tick = aux_tick && wake_down_reg && (wake_cnt_reg == 13'h0001); // R2

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      aux_div_reg   <= 10'h000;
      wake_cnt_reg  <= 13'h0000;
      wake_down_reg <= 1'b0;
      lcd_div_reg   <= 6'h00;
      lcd_com_reg   <= 2'h0;
    end else begin
      aux_div_reg <= aux_tick ? 10'h000 : aux_div_reg + 10'h001;
      if (aux_tick) begin // R1
        wake_cnt_reg <= wake_down_reg ? wake_cnt_reg - 13'h0001 : wake_cnt_reg + 13'h0001;
        if (!wake_down_reg && wake_cnt_reg == 13'(WAKE_HALF - 1))
          wake_down_reg <= 1'b1;
        else if (wake_down_reg && wake_cnt_reg == 13'h0001)
          wake_down_reg <= 1'b0;
        lcd_div_reg <= lcd_div_reg + 6'h01; // R13
      end
      lcd_com_reg <= lcd_div_reg[5:4]; // R13
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // register file and ahb-lite slave
  logic [8:0]             ctrl_reg;   // [8:1] arm seconds, [0] two-coil
  logic [`TSS_NUM_EV-1:0] status_reg;
  logic [`TSS_NUM_EV-1:0] mask_reg;
  logic [`TSS_NUM_EV-1:0] ev_set;
  logic [`TSS_NUM_EV-1:0] status_clr;
  logic [`TSS_NUM_EV-1:0] status_next;
  tss_aphase_type         aph_reg;
  logic                   dph_wr_reg;
  logic                   ahb_go;
  logic [31:0]            rd_mux;
  logic                   wr_ctrl;
  logic                   wr_status;
  logic                   wr_mask;
  logic [15:0]            rtc_sec_reg;
  logic [15:0]            first_time_reg;
  logic                   first_valid_reg;
  logic                   armed_reg;
  logic [3:0]             tick_cnt_reg;
  logic                   two_coil;
  logic [7:0]             arm_secs;

  assign two_coil   = ctrl_reg[0];
  assign arm_secs   = ctrl_reg[8:1];
  assign ahb_go     = hsel && htrans[1] && hready;
  assign wr_ctrl    = dph_wr_reg && (aph_reg.addr == `TSS_OFS_CTRL);
  assign wr_status  = dph_wr_reg && (aph_reg.addr == `TSS_OFS_STATUS);
  assign wr_mask    = dph_wr_reg && (aph_reg.addr == `TSS_OFS_MASK);
  assign status_clr = wr_status ? hwdata[`TSS_NUM_EV-1:0] : '0;
  // set beats write-one-to-clear in the same cycle
  assign status_next = (status_reg & ~status_clr) | ev_set;
  assign rd_mux =
    (haddr[7:0] == `TSS_OFS_CTRL)   ? {23'h000000, ctrl_reg} :
    (haddr[7:0] == `TSS_OFS_STATUS) ? {28'h0000000, status_reg} :
    (haddr[7:0] == `TSS_OFS_MASK)   ? {28'h0000000, mask_reg} :
    (haddr[7:0] == `TSS_OFS_STATE)  ? {22'h000000, disp_param_reg, tick_cnt_reg,
                                       first_valid_reg, supply_backup_reg,
                                       sensor_en_reg, armed_reg} :
    (haddr[7:0] == `TSS_OFS_FIRST)  ? {16'h0000, first_time_reg} :
    (haddr[7:0] == `TSS_OFS_RTC)    ? {16'h0000, rtc_sec_reg} : 32'h00000000;

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      aph_reg       <= '0;
      dph_wr_reg    <= 1'b0;
      hrdata_reg    <= 32'h00000000;
      hreadyout_reg <= 1'b1;
      hresp_reg     <= 1'b0;
      ctrl_reg      <= `TSS_CTRL_RST | {`TSS_ARM_SECS_RST, 1'b0};
      status_reg    <= '0;
      mask_reg      <= '0;
      irq_reg       <= 1'b0;
    end else begin
      if (hready) begin
        aph_reg    <= '{wr: hwrite, addr: haddr[7:0]};
        dph_wr_reg <= ahb_go && hwrite;
        if (ahb_go && !hwrite)
          hrdata_reg <= rd_mux;
      end
      if (wr_ctrl)
        ctrl_reg <= hwdata[8:0]; // R7
      if (wr_mask)
        mask_reg <= hwdata[`TSS_NUM_EV-1:0];
      status_reg <= status_next;
      irq_reg    <= |(status_next & (wr_mask ? hwdata[`TSS_NUM_EV-1:0] : mask_reg));
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // rtc seconds, arming, supply selection
  logic [15:0] rtc_sub_reg;
  logic        sec_tick;

  assign sec_tick = aux_tick && (rtc_sub_reg == 16'(AUX_PER_SEC - 1));

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rtc_sub_reg       <= 16'h0000;
      rtc_sec_reg       <= 16'h0000;
      armed_reg         <= 1'b0; // R17
      supply_backup_reg <= 1'b0;
    end else begin
      if (aux_tick)
        rtc_sub_reg <= sec_tick ? 16'h0000 : rtc_sub_reg + 16'h0001;
      if (sec_tick)
        rtc_sec_reg <= rtc_sec_reg + 16'h0001;
      if (rtc_sec_reg >= {8'h00, arm_secs})
        armed_reg <= 1'b1; // R9
      if (main_ok)
        supply_backup_reg <= 1'b0;
      else if (backup_ok)
        supply_backup_reg <= 1'b1; // R14
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // sample sequencer
  tss_seq_type seq_reg;
  logic [7:0]  pulse_cnt_reg;
  logic [3:0]  tick_inc;
  logic        sense_tick;
  logic        pulse_done;
  logic [7:0]  term;
  logic        read_ok;
  logic        tamper_now;
  logic        sup_prev_reg;

  assign tick_inc   = tick_cnt_reg + 4'h1;
  assign sense_tick = wake_tick && (tick_inc == `TSS_TICK_SENSE_A || tick_inc == `TSS_TICK_LAST);
  assign term       = two_coil ? 8'(TERM2) : 8'(TERM1); // R7 R8 R16
  assign pulse_done = aux_tick && (pulse_cnt_reg == term - 8'h01); // R6
  assign read_ok    = (seq_reg == TSS_READ) && armed_reg && sensor_en_reg; // R9 R18
  assign tamper_now = read_ok && sensor_out;

  assign ev_set[`TSS_ST_WAKE]   = wake_tick;
  assign ev_set[`TSS_ST_SAMPLE] = read_ok;
  assign ev_set[`TSS_ST_TAMPER] = tamper_now;
  assign ev_set[`TSS_ST_SUPPLY] = supply_backup_reg != sup_prev_reg;

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      seq_reg            <= TSS_IDLE;
      tick_cnt_reg       <= 4'h0; // R17
      pulse_cnt_reg      <= 8'h00;
      sensor_en_reg      <= 1'b0;
      disp_param_reg     <= 2'h0;
      lcd_supply_sym_reg <= 1'b0;
      lcd_tamper_sym_reg <= 1'b0;
      led_tamper_reg     <= 1'b0;
      first_valid_reg    <= 1'b0;
      first_time_reg     <= 16'h0000;
      sup_prev_reg       <= 1'b0;
    end else begin
      sup_prev_reg <= supply_backup_reg;
      if (wake_tick) begin
        lcd_supply_sym_reg <= supply_backup_reg; // R3
        if (tick_inc == `TSS_TICK_LAST) begin
          tick_cnt_reg   <= 4'h0; // R4
          disp_param_reg <= disp_param_reg + 2'h1;
        end else begin
          tick_cnt_reg <= tick_inc;
        end
      end
      unique case (seq_reg)
        TSS_IDLE: begin
          if (sense_tick) begin
            sensor_en_reg <= 1'b1; // R5
            pulse_cnt_reg <= 8'h00;
            seq_reg       <= TSS_PULSE;
          end
        end
        TSS_PULSE: begin
          if (aux_tick)
            pulse_cnt_reg <= pulse_cnt_reg + 8'h01; // R6
          if (pulse_done)
            seq_reg <= TSS_READ;
        end
        TSS_READ: begin
          if (read_ok) begin
            lcd_tamper_sym_reg <= sensor_out; // R10
            if (!supply_backup_reg)
              led_tamper_reg <= sensor_out; // R11
          end
          sensor_en_reg <= 1'b0; // R12
          seq_reg       <= TSS_IDLE;
        end
        default: seq_reg <= TSS_IDLE;
      endcase
      // a new tamper in the clearing cycle is kept as the first
      if (tamper_now && (!first_valid_reg || clear_button)) begin
        first_valid_reg <= 1'b1; // R15
        first_time_reg  <= rtc_sec_reg;
      end else if (clear_button && main_ok) begin
        first_valid_reg <= 1'b0; // R15
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // checks
  logic [31:0] en_len_reg;
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn)
      en_len_reg <= 32'h00000000;
    else
      en_len_reg <= sensor_en_reg ? en_len_reg + 32'h00000001 : 32'h00000000;
  end

  AST_WAKE_UPDOWN: assert property (@(posedge clock) disable iff (!resetn) // R2
    wake_tick |=> !wake_down_reg && wake_cnt_reg == 13'h0000)
    else $error("wake tick not at the bottom of the up/down count");
  AST_TICK_WRAP: assert property (@(posedge clock) disable iff (!resetn) // R4
    wake_tick && tick_cnt_reg == 4'h7 |=> tick_cnt_reg == 4'h0
      && disp_param_reg == $past(disp_param_reg) + 2'h1)
    else $error("tick counter did not wrap with display advance");
  AST_EN_CAUSE: assert property (@(posedge clock) disable iff (!resetn) // R5
    $rose(sensor_en_reg) |-> $past(wake_tick)
      && ($past(tick_cnt_reg) == 4'h3 || $past(tick_cnt_reg) == 4'h7))
    else $error("sensor enable rose outside tick 4 or 8");
  AST_PULSE_LEN: assert property (@(posedge clock) disable iff (!resetn) // R8
    $fell(sensor_en_reg) |-> $past(en_len_reg) >= 32'((TERM1 - 1) * AUX_DIV))
    else $error("sensor enable pulse too short");
  AST_READ_IN_EN: assert property (@(posedge clock) disable iff (!resetn) // R18
    $changed(lcd_tamper_sym_reg) |-> $past(sensor_en_reg) && $past(seq_reg) == TSS_READ)
    else $error("tamper symbol changed outside an enable pulse");
  AST_ARMED_GATE: assert property (@(posedge clock) disable iff (!resetn) // R9
    $changed(lcd_tamper_sym_reg) |-> $past(armed_reg))
    else $error("sensor read before arming");
  AST_LED_MAIN: assert property (@(posedge clock) disable iff (!resetn) // R11
    $changed(led_tamper_reg) |-> !$past(supply_backup_reg))
    else $error("tamper led changed while on backup");
  AST_EN_DROP: assert property (@(posedge clock) disable iff (!resetn) // R12
    seq_reg == TSS_READ |=> !sensor_en_reg && seq_reg == TSS_IDLE)
    else $error("enable not dropped after read");
  AST_SUPPLY: assert property (@(posedge clock) disable iff (!resetn) // R14
    !main_ok && backup_ok |=> supply_backup_reg)
    else $error("backup supply not selected");
  AST_SUPPLY_SYM: assert property (@(posedge clock) disable iff (!resetn) // R3
    wake_tick |=> lcd_supply_sym_reg == $past(supply_backup_reg))
    else $error("supply symbol not refreshed on wake tick");
  AST_FIRST_HOLD: assert property (@(posedge clock) disable iff (!resetn) // R15
    first_valid_reg && !clear_button |=> $stable(first_time_reg))
    else $error("first tamper time overwritten");
  AST_LCD_COM: assert property (@(posedge clock) disable iff (!resetn) // R13
    $changed(lcd_div_reg) |-> $past(aux_tick))
    else $error("display refresh divider moved off the aux tick");
endmodule : tss_top

// *** tb/tb_top.sv ***
`timescale 1ns/1ps
`define CHECK(a, b) begin comparisons++; if ((a) !== (b)) begin failures++; \
  $display("unexpected at %0t: got %h want %h", $time, a, b); end end
module tb_top import tss_pkg::*;;
  localparam int AUX_SEC = 4;
  localparam int AUX_CLKS = 765;
  localparam int SEC_CLKS = AUX_SEC * AUX_CLKS;
  localparam int WAKE_HALF = 2;
  localparam int WAKE_CLKS = 2 * WAKE_HALF * AUX_CLKS;
  localparam int CLK_PER_US = 25;
  logic clock = 0, resetn = 0, hsel = 0, hwrite = 0, sensor_out, tamper = 0;
  logic main_ok = 1, backup_ok = 1, clear_button = 0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata_reg, rd;
  logic [1:0] htrans = 0, lcd_com_reg, disp_param_reg;
  logic [2:0] hsize = 3'h2;
  logic hreadyout_reg, hresp_reg, sensor_en_reg, supply_backup_reg;
  logic lcd_supply_sym_reg, lcd_tamper_sym_reg, led_tamper_reg, irq_reg, coil;
  int failures = 0, comparisons = 0, seed = 29, cycle = 0, rel, t0, n;
  logic [31:0] mask_val, first_sec;
  logic [1:0]  com0;
  int          t1, len;
  always #20 clock = ~clock;
  always @(posedge clock) cycle <= cycle + 1;
  tss_top #(.AUX_PER_SEC(AUX_SEC), .WAKE_HALF(WAKE_HALF)) i_dut (
    .clock(clock), .resetn(resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout_reg),
    .hrdata_reg(hrdata_reg), .hreadyout_reg(hreadyout_reg), .hresp_reg(hresp_reg),
    .sensor_out(sensor_out), .main_ok(main_ok), .backup_ok(backup_ok),
    .clear_button(clear_button), .sensor_en_reg(sensor_en_reg),
    .supply_backup_reg(supply_backup_reg), .lcd_supply_sym_reg(lcd_supply_sym_reg),
    .lcd_tamper_sym_reg(lcd_tamper_sym_reg), .led_tamper_reg(led_tamper_reg),
    .lcd_com_reg(lcd_com_reg), .disp_param_reg(disp_param_reg), .irq_reg(irq_reg));
  tss_sensor_model i_sensor (.clock(clock), .sensor_en(sensor_en_reg), .tamper(tamper),
    .sensor_out(sensor_out));
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] exp_ctrl(input logic [7:0] arm, input logic two);
    exp_ctrl = {23'h0, arm, two};
  endfunction : exp_ctrl
  function automatic logic [31:0] exp_rtc(input int clks);
    exp_rtc = 32'(clks / SEC_CLKS);
  endfunction : exp_rtc
  // shortest legal enable pulse in clocks for the chosen coil variant
  function automatic int exp_pulse(input logic two);
    exp_pulse = (two ? 1237 : 1003) * CLK_PER_US;
  endfunction : exp_pulse
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= wr;
    haddr <= {24'h0, a};
    do @(posedge clock); while (hreadyout_reg !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge clock); while (hreadyout_reg !== 1'b1);
    rd = hrdata_reg;
    `CHECK(hresp_reg, 1'b0)
  endtask : ahb
  task automatic wait_backup(input logic v);
    n = 0;
    while (supply_backup_reg !== v && n < 2000) begin
      @(posedge clock);
      n++;
    end
  endtask : wait_backup
  task automatic sense_pulse(input int rise_at, input logic [1:0] disp);
    while (sensor_en_reg !== 1'b1) @(posedge clock);
    t0 = cycle;
    `CHECK(t0 >= rise_at - 4 && t0 <= rise_at + 4, 1'b1)
    `CHECK(disp_param_reg, disp)
    while (sensor_en_reg === 1'b1) @(posedge clock);
    len = cycle - t0;
    `CHECK(len >= exp_pulse(coil) && len <= exp_pulse(coil) + 2 * AUX_CLKS, 1'b1)
  endtask : sense_pulse
  task automatic give_verdict;
    if (failures == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : give_verdict
  initial begin
    repeat (100000) @(posedge clock);
    failures++;
    give_verdict;
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($random(seed));
    repeat (16) @(posedge clock);
    #1;
    `CHECK({sensor_en_reg, irq_reg, hreadyout_reg}, 3'b001)
    resetn <= 1'b1;
    rel = cycle + 1;
    ahb(1'b0, 8'h0c, 0);
    `CHECK(rd, 32'h0)
    ahb(1'b0, 8'h00, 0);
    `CHECK(rd, exp_ctrl(8'h0a, 1'b0))
    coil = 1'($random(seed));
    ahb(1'b1, 8'h00, exp_ctrl(8'h02, coil));
    ahb(1'b0, 8'h00, 0);
    `CHECK(rd, exp_ctrl(8'h02, coil))
    ahb(1'b0, 8'h0c, 0);
    `CHECK(rd[0], 1'b0)
    ahb(1'b1, 8'h18, 32'hffffffff);
    ahb(1'b0, 8'h18, 0);
    `CHECK(rd, 32'h0)
    mask_val = $random(seed);
    ahb(1'b1, 8'h08, {28'h0, mask_val[3:0]});
    ahb(1'b0, 8'h08, 0);
    `CHECK(rd, {28'h0, mask_val[3:0]})
    // clear with nothing captured must leave first_valid low
    @(posedge clock) clear_button <= 1'b1;
    @(posedge clock) clear_button <= 1'b0;
    // no switch while the backup is too low
    backup_ok <= 1'b0;
    main_ok <= 1'b0;
    repeat (50) @(posedge clock);
    `CHECK(supply_backup_reg, 1'b0)
    ahb(1'b1, 8'h04, 32'hf);
    ahb(1'b1, 8'h08, 32'h8);
    backup_ok <= 1'b1;
    wait_backup(1'b1);
    `CHECK(supply_backup_reg, 1'b1)
    repeat (3) @(posedge clock);
    `CHECK(irq_reg, 1'b1)
    ahb(1'b0, 8'h0c, 0);
    `CHECK(rd[3:2], 2'b01)
    ahb(1'b1, 8'h04, 32'h8);
    repeat (3) @(posedge clock);
    `CHECK(irq_reg, 1'b0)
    ahb(1'b1, 8'h08, 32'h0);
    main_ok <= 1'b1;
    wait_backup(1'b0);
    `CHECK(supply_backup_reg, 1'b0)
    ahb(1'b0, 8'h04, 0);
    `CHECK(rd[3], 1'b1)
    `CHECK(irq_reg, 1'b0)
    fork
      begin
        // common phase steps every 16 aux ticks
        com0 = lcd_com_reg;
        while (lcd_com_reg === com0) @(posedge clock);
        t1 = cycle;
        com0 = lcd_com_reg;
        while (lcd_com_reg === com0) @(posedge clock);
        `CHECK(cycle - t1, 16 * AUX_CLKS)
      end
      begin
        // mid-second read keeps the rtc check off the boundary
        while (cycle < rel + 3 * SEC_CLKS + SEC_CLKS / 2) @(posedge clock);
        ahb(1'b0, 8'h14, 0);
        `CHECK(rd, exp_rtc(3 * SEC_CLKS + SEC_CLKS / 2))
        ahb(1'b0, 8'h0c, 0);
        `CHECK(rd[0], 1'b1)
        `CHECK(rd[3], 1'b0)
        `CHECK(sensor_en_reg, 1'b0)
        // first pulse at wake tick 4, on main supply, target away
        tamper <= 1'b1;
        sense_pulse(rel + 4 * WAKE_CLKS, 2'h0);
        `CHECK({lcd_tamper_sym_reg, led_tamper_reg}, 2'b11)
        first_sec = exp_rtc(cycle - rel);
        ahb(1'b0, 8'h04, 0);
        `CHECK(rd[2:1], 2'b11)
        // pulse spans tick 12, so the next one is tick 16, now on backup
        main_ok <= 1'b0;
        tamper <= 1'b0;
        sense_pulse(rel + 16 * WAKE_CLKS, 2'h2);
        `CHECK(lcd_tamper_sym_reg, 1'b0)
        `CHECK(led_tamper_reg, 1'b1)
        ahb(1'b0, 8'h10, 0);
        `CHECK(rd, first_sec)
        // clear is ignored without main supply
        @(posedge clock) clear_button <= 1'b1;
        @(posedge clock) clear_button <= 1'b0;
        ahb(1'b0, 8'h0c, 0);
        `CHECK(rd[3], 1'b1)
        main_ok <= 1'b1;
        @(posedge clock) clear_button <= 1'b1;
        @(posedge clock) clear_button <= 1'b0;
        ahb(1'b0, 8'h0c, 0);
        `CHECK(rd[3], 1'b0)
      end
    join
    give_verdict;
  end
endmodule : tb_top

// *** tb/tss_sensor_model.sv ***
`timescale 1ns/1ps
module tss_sensor_model #(
  parameter int CONV_CYCLES = 6900  // conversion time in clocks
) (
  input  wire logic clock,      // system clock
  input  wire logic sensor_en,  // enable from the sequencer
  input  wire logic tamper,     // target away when high
  output logic      sensor_out  // switch output
);
  int   conv_cnt;
  initial begin
    conv_cnt = 0;
    sensor_out = 1'b0;
  end
  // no valid output while disabled or converting, so the line keeps moving
  always @(posedge clock) begin
    if (sensor_en && conv_cnt >= CONV_CYCLES) begin
      sensor_out <= tamper;
    end else begin
      sensor_out <= ~sensor_out;
    end
    conv_cnt <= sensor_en ? conv_cnt + 1 : 0;
  end
endmodule : tss_sensor_model
